/* File: design/tdcr_pkg.sv */
// Constants for the time-to-digital converter result path.
package tdcr_pkg;
    // ==================================================================
    // Geometry
    localparam int NCH    = 8;
    localparam int HDEPTH = 32;
    localparam int IDEPTH = 256;
    localparam int TW     = 17;
    localparam int HW     = TW + 1;
    localparam int DW     = 28;
    // ==================================================================
    // Register addresses
    localparam logic [3:0] ADR_CTRL  = 4'h4;
    localparam logic [3:0] ADR_CFG   = 4'h5;
    localparam logic [3:0] ADR_FILL  = 4'h6;
    localparam logic [3:0] ADR_TIMER = 4'h7;
    localparam logic [3:0] ADR_Q0    = 4'h8;
    localparam logic [3:0] ADR_Q1    = 4'h9;
    localparam logic [3:0] ADR_ERRM  = 4'hB;
    localparam logic [3:0] ADR_STAT  = 4'hC;
    localparam logic [3:0] ADR_BUSW  = 4'hE;
    // ==================================================================
    // Field positions
    localparam int CTRL_FULL_RST  = 22;
    localparam int CTRL_PART_RST  = 24;
    localparam int CTRL_TL_START  = 25;
    localparam int CTRL_TL_STOP   = 26;
    localparam int CFG_STOP_GATE  = 21;
    localparam int CFG_START_LOCK = 22;
    localparam int CFG_FULL_PIN   = 23;
    localparam int CFG_PART_PIN   = 24;
    localparam int STAT_MASK_LSB  = 13;
    localparam int ERRM_LSB       = 16;
    localparam int ERRM_MSB       = 26;
    localparam int TMR_W          = 13;
    // ==================================================================
    // Reset values and codes
    localparam logic [DW-1:0] CFG_RST    = 28'h0000000;
    localparam logic [DW-1:0] BUS16_CODE = 28'h0000010;
    // ==================================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int GATE_DELAY_NS = 7;
    localparam int OPEN_FULL_NS  = 40;
    localparam int OPEN_PART_NS  = 75;
    localparam int GATE_CYC  = (GATE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OPEN_FULL_CYC = (OPEN_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OPEN_PART_CYC = (OPEN_PART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* File: design/tdcr_top.sv */
// Result path of the eight-channel converter: gating, hit queues, collector, output queues.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module tdcr_top
    import tdcr_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic [3:0]                addr,
    input  wire logic [DW-1:0]             wdata,
    input  wire logic                      wr,
    input  wire logic                      rd,
    output wire logic [DW-1:0]             rdata,
    input  wire logic                      start_hit,
    input  wire logic [TW-1:0]             start_time,
    input  wire logic [NCH-1:0]            stop_hit,
    input  wire logic [NCH-1:0][TW-1:0]    stop_time,
    input  wire logic [NCH-1:0]            stop_slope,
    input  wire logic                      alu_trigger,
    input  wire logic                      pll_locked,
    output wire logic [1:0]                queue_empty_flag,
    output wire logic [1:0]                queue_level_flag,
    output wire logic                      irq,
    output wire logic                      err
);
    // ==================================================================
    // Configuration registers
    logic [DW-1:0]     ctrl_reg, cfg_reg, busw_reg;
    logic [7:0]        fill_reg;
    logic [TMR_W-1:0]  tper_reg;
    logic [10:0]       errm_reg;
    logic [14:0]       statm_reg;
    wire logic wr_ctrl  = wr && addr == ADR_CTRL;
    wire logic bus16    = busw_reg == BUS16_CODE;
    wire logic stat_rd  = rd && addr == ADR_STAT;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg  <= CFG_RST;
            cfg_reg   <= CFG_RST;
            busw_reg  <= CFG_RST;
            fill_reg  <= 8'h00;
            tper_reg  <= 13'h0000;
            errm_reg  <= 11'h000;
            statm_reg <= 15'h0000;
        end else if (wr) begin
            case (addr)
                ADR_CTRL:  ctrl_reg  <= wdata;
                ADR_CFG:   cfg_reg   <= wdata;
                ADR_FILL:  fill_reg  <= wdata[7:0];
                ADR_TIMER: tper_reg  <= wdata[TMR_W-1:0];
                ADR_ERRM:  errm_reg  <= wdata[ERRM_MSB:ERRM_LSB];
                ADR_STAT:  statm_reg <= wdata[DW-1:STAT_MASK_LSB];
                ADR_BUSW:  busw_reg  <= wdata;
                default:   ;
            endcase
        end
    end

    // ==================================================================
    // Soft resets; configuration is never touched by these.
    wire logic full_rst = (wr_ctrl && wdata[CTRL_FULL_RST])
                        || (alu_trigger && cfg_reg[CFG_FULL_PIN]);
    wire logic part_rst = (wr_ctrl && wdata[CTRL_PART_RST])
                        || (alu_trigger && cfg_reg[CFG_PART_PIN]);
    wire logic any_rst  = full_rst || part_rst;

    // ==================================================================
    // Input gating
    logic [3:0]    open_cnt_reg;
    logic [3:0]    gate_cnt_reg;
    logic          start_seen_reg;
    logic [TW-1:0] start_time_reg;
    logic [7:0]    start_idx_reg;
    wire logic inputs_open = open_cnt_reg == 4'h0;
    wire logic start_acc = start_hit && inputs_open
                         && !(cfg_reg[CFG_START_LOCK] && start_seen_reg);
    wire logic stops_ok  = inputs_open && (!cfg_reg[CFG_STOP_GATE]
                         || (start_seen_reg && gate_cnt_reg == 4'h0));

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            open_cnt_reg <= 4'(OPEN_FULL_CYC);
        else if (full_rst)
            open_cnt_reg <= 4'(OPEN_FULL_CYC);
        else if (part_rst)
            open_cnt_reg <= 4'(OPEN_PART_CYC);
        else if (!inputs_open)
            open_cnt_reg <= open_cnt_reg - 4'h1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_seen_reg <= 1'b0;
            gate_cnt_reg   <= 4'h0;
            start_time_reg <= 17'h00000;
            start_idx_reg  <= 8'h00;
        end else if (any_rst) begin
            start_seen_reg <= 1'b0;
            gate_cnt_reg   <= 4'h0;
            start_idx_reg  <= 8'h00;
        end else begin
            if (start_acc && !start_seen_reg)
                gate_cnt_reg <= 4'(GATE_CYC);
            else if (gate_cnt_reg != 4'h0)
                gate_cnt_reg <= gate_cnt_reg - 4'h1;
            if (start_acc) begin
                start_seen_reg <= 1'b1;
                start_time_reg <= start_time;
                start_idx_reg  <= start_idx_reg + 8'(start_seen_reg);
            end
        end
    end

    // ==================================================================
    // Hit queues
    logic [NCH-1:0]         hpush, hpop, hfull, hempty, avail;
    logic [NCH-1:0][HW-1:0] hhead;
    logic [1:0]             iroom, ifull;

    for (genvar g = 0; g < NCH; g++) begin : g_hit
        logic [HW-1:0] mem [HDEPTH];
        logic [4:0]    wp_reg, rp_reg;
        logic [5:0]    cnt_reg;
        assign hfull[g]  = cnt_reg == 6'(HDEPTH);
        assign hempty[g] = cnt_reg == 6'h00;
        assign hhead[g]  = mem[rp_reg];
        assign hpush[g]  = stop_hit[g] && stops_ok && !hfull[g];
        assign avail[g]  = !hempty[g] && iroom[g / 4];
        always_ff @(posedge clk) begin
            if (hpush[g])
                mem[wp_reg] <= {stop_slope[g], stop_time[g]};
        end
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                wp_reg  <= 5'h00;
                rp_reg  <= 5'h00;
                cnt_reg <= 6'h00;
            end else if (any_rst) begin
                wp_reg  <= 5'h00;
                rp_reg  <= 5'h00;
                cnt_reg <= 6'h00;
            end else begin
                wp_reg  <= wp_reg + 5'(hpush[g]);
                rp_reg  <= rp_reg + 5'(hpop[g]);
                cnt_reg <= cnt_reg + 6'(hpush[g]) - 6'(hpop[g]);
            end
        end
    end

    // ==================================================================
    // Collector and post-processing stage
    function automatic logic [3:0] rr_pick(input logic [NCH-1:0] req, input logic [2:0] from);
        logic [3:0] res;
        logic [2:0] idx;
        res = 4'h0;
        for (int j = NCH - 1; j >= 0; j--) begin
            idx = from + 3'(j);
            if (req[idx])
                res = {1'b1, idx};
        end
        return res;
    endfunction

    logic [2:0]    rr_reg;
    logic          pipe_v_reg;
    logic          pipe_sel_reg;
    logic [DW-1:0] pipe_word_reg;
    wire logic [3:0]    pick = rr_pick(avail, rr_reg);
    wire logic [2:0]    pidx = pick[2:0];
    wire logic [HW-1:0] phead = hhead[pidx];
    wire logic [TW-1:0] pdiff = phead[TW-1:0] - start_time_reg + cfg_reg[TW-1:0];
    assign hpop = pick[3] ? (8'h01 << pidx) : 8'h00;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rr_reg        <= 3'h0;
            pipe_v_reg    <= 1'b0;
            pipe_sel_reg  <= 1'b0;
            pipe_word_reg <= 28'h0000000;
        end else if (any_rst) begin
            rr_reg     <= 3'h0;
            pipe_v_reg <= 1'b0;
        end else begin
            pipe_v_reg <= pick[3];
            if (pick[3]) begin
                rr_reg        <= pidx + 3'h1;
                pipe_sel_reg  <= pidx[2];
                pipe_word_reg <= {pidx[1:0], start_idx_reg, phead[TW], pdiff};
            end
        end
    end

    // ==================================================================
    // Interface queues
    logic [1:0]          ipush, ipop, half_reg, empty_reg, level_reg;
    logic [1:0][DW-1:0]  ihead;

    for (genvar k = 0; k < 2; k++) begin : g_ifq
        logic [DW-1:0] mem [IDEPTH];
        logic [7:0]    wp_reg, rp_reg;
        logic [8:0]    cnt_reg;
        wire logic [8:0] cnt_next = cnt_reg + 9'(ipush[k]) - 9'(ipop[k]);
        wire logic       q_rd = rd && addr == (ADR_Q0 + 4'(k));
        assign ifull[k] = cnt_reg == 9'(IDEPTH);
        assign iroom[k] = (cnt_reg + 9'(ipush[k])) < 9'(IDEPTH);
        assign ihead[k] = mem[rp_reg];
        assign ipush[k] = pipe_v_reg && pipe_sel_reg == 1'(k);
        assign ipop[k]  = q_rd && cnt_reg != 9'h000 && (!bus16 || half_reg[k]);
        always_ff @(posedge clk) begin
            if (ipush[k])
                mem[wp_reg] <= pipe_word_reg;
        end
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                wp_reg       <= 8'h00;
                rp_reg       <= 8'h00;
                cnt_reg      <= 9'h000;
                half_reg[k]  <= 1'b0;
                empty_reg[k] <= 1'b1;
                level_reg[k] <= 1'b0;
            end else if (full_rst) begin
                wp_reg       <= 8'h00;
                rp_reg       <= 8'h00;
                cnt_reg      <= 9'h000;
                half_reg[k]  <= 1'b0;
                empty_reg[k] <= 1'b1;
                level_reg[k] <= 1'b0;
            end else begin
                wp_reg       <= wp_reg + 8'(ipush[k]);
                rp_reg       <= rp_reg + 8'(ipop[k]);
                cnt_reg      <= cnt_next;
                if (q_rd && bus16 && cnt_reg != 9'h000)
                    half_reg[k] <= !half_reg[k];
                empty_reg[k] <= cnt_next == 9'h000;
                level_reg[k] <= cnt_next >= {1'b0, fill_reg};
            end
        end
    end

    // ==================================================================
    // Measurement timer
    logic [TMR_W-1:0] tmr_cnt_reg;
    logic             tmr_run_reg, timer_expired_flag_reg;
    wire logic launch = (ctrl_reg[CTRL_TL_START] && start_acc)
                      || (ctrl_reg[CTRL_TL_STOP] && |hpush);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tmr_cnt_reg            <= 13'h0000;
            tmr_run_reg            <= 1'b0;
            timer_expired_flag_reg <= 1'b0;
        end else if (any_rst) begin
            tmr_run_reg            <= 1'b0;
            timer_expired_flag_reg <= 1'b0;
        end else if (tmr_run_reg) begin
            tmr_cnt_reg <= tmr_cnt_reg - 13'h0001;
            if (tmr_cnt_reg <= 13'h0001) begin
                tmr_run_reg            <= 1'b0;
                timer_expired_flag_reg <= 1'b1;
            end
        end else if (launch) begin
            tmr_cnt_reg            <= tper_reg;
            tmr_run_reg            <= 1'b1;
            timer_expired_flag_reg <= 1'b0;
        end
    end

    // ==================================================================
    // Status, interrupt and error
    logic [NCH-1:0] hq_sticky_reg;
    logic [1:0]     iq_sticky_reg;
    logic           irq_reg, err_reg;
    logic [DW-1:0]  rdata_reg;
    wire logic [12:0] int_ev = {timer_expired_flag_reg, &hempty, !pll_locked,
                                iq_sticky_reg, hq_sticky_reg};
    wire logic [DW-1:0] stat_word = {statm_reg, int_ev};
    wire logic [DW-1:0] qword = ihead[addr[0]];
    wire logic [DW-1:0] qdata = !bus16 ? qword : half_reg[addr[0]]
                              ? {16'h0000, qword[DW-1:16]} : {12'h000, qword[15:0]};
    logic [DW-1:0] rdata_next;
    always_comb begin
        case (addr)
            ADR_CTRL:         rdata_next = ctrl_reg;
            ADR_CFG:          rdata_next = cfg_reg;
            ADR_FILL:         rdata_next = {20'h00000, fill_reg};
            ADR_TIMER:        rdata_next = {15'h0000, tper_reg};
            ADR_Q0, ADR_Q1:   rdata_next = qdata;
            ADR_ERRM:         rdata_next = {1'b0, errm_reg, 16'h0000};
            ADR_STAT:         rdata_next = stat_word;
            ADR_BUSW:         rdata_next = busw_reg;
            default:          rdata_next = 28'h0000000;
        endcase
    end

    // A new full condition in the read cycle survives the clear.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hq_sticky_reg <= 8'h00;
            iq_sticky_reg <= 2'h0;
            irq_reg       <= 1'b0;
            err_reg       <= 1'b0;
            rdata_reg     <= 28'h0000000;
        end else begin
            hq_sticky_reg <= any_rst ? 8'h00 : hfull | (hq_sticky_reg & {NCH{!stat_rd}});
            iq_sticky_reg <= any_rst ? 2'h0 : ifull | (iq_sticky_reg & {2{!stat_rd}});
            irq_reg       <= |(int_ev & statm_reg[12:0]);
            err_reg       <= |(int_ev[10:0] & errm_reg);
            rdata_reg     <= rd ? rdata_next : 28'h0000000;
        end
    end

    assign rdata            = rdata_reg;
    assign queue_empty_flag = empty_reg;
    assign queue_level_flag = level_reg;
    assign irq              = irq_reg;
    assign err              = err_reg;

    // ==================================================================
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_full_rst;
        full_rst && !part_rst;
    endsequence
    sequence s_closed_four;
        !inputs_open [*4];
    endsequence
    a_open_delay: assert property (s_full_rst |=> s_closed_four ##1 (inputs_open || any_rst))
        else $error("Inputs open at wrong time after full reset");
    a_stop_gated: assert property (|hpush && cfg_reg[CFG_STOP_GATE] |-> $past(start_seen_reg))
        else $error("Stop accepted before start");
    a_gate_delay: assert property ($rose(start_seen_reg) && cfg_reg[CFG_STOP_GATE]
                                   |-> !(|hpush))
        else $error("Stop accepted too soon after start");
    a_start_lock: assert property (start_seen_reg && cfg_reg[CFG_START_LOCK] |-> !start_acc)
        else $error("Start accepted while locked");
    a_one_pop: assert property ($onehot0(hpop))
        else $error("More than one hit popped per cycle");
    a_full_drop: assert property (stop_hit[0] && hfull[0] && !hpop[0] && !any_rst
                                  |=> hfull[0])
        else $error("Full hit queue changed state on drop");
    a_rr_next: assert property (pick[3] && avail[pidx + 3'h1] && !any_rst
                                |=> !pick[3] || pidx == $past(pidx) + 3'h1)
        else $error("Round robin skipped ready neighbour");
    a_read_pop: assert property (rd && addr == ADR_Q0 && !bus16 && !empty_reg[0]
                                 && !ipush[0] && !full_rst |=> $past(g_ifq[0].cnt_reg)
                                 == g_ifq[0].cnt_reg + 9'h001)
        else $error("Queue read did not pop one word");
    a_irq_or: assert property ((statm_reg[12] && timer_expired_flag_reg)
                               || (statm_reg[10] && !pll_locked)
                               || (statm_reg[11] && &hempty) |=> irq)
        else $error("Interrupt does not match events");
endmodule

/* File: verification/tdcr_host_model.sv */
// Host reader model: drives the register bus and drains the output queues.
`timescale 1ns/1ps
module tdcr_host_model
    import tdcr_pkg::*;
(
    input  wire logic          clk,
    input  wire logic [DW-1:0] rdata,
    input  wire logic [1:0]    queue_empty_flag,
    output logic [3:0]         addr,
    output logic [DW-1:0]      wdata,
    output logic               wr,
    output logic               rd
);
    initial begin
        addr  = 4'h0;
        wdata = '0;
        wr    = 1'b0;
        rd    = 1'b0;
    end
    // ==================================================================
    // Bus cycles
    task automatic reg_wr(input logic [3:0] a, input logic [DW-1:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [DW-1:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask
    // ==================================================================
    // Queue read: an empty queue is never read; a stall waits up to 60 cycles, then returns x.
    task automatic pop(input int q, input bit w16, output logic [DW-1:0] w);
        int n;
        logic [DW-1:0] lo;
        logic [DW-1:0] hi;
        n = 0;
        w = 'x;
        while (queue_empty_flag[q] !== 1'b0 && n < 60) begin
            @(posedge clk);
            n++;
        end
        if (n < 60) begin
            reg_rd(ADR_Q0 + 4'(q), lo);
            if (w16) begin
                reg_rd(ADR_Q0 + 4'(q), hi);
                lo = {hi[11:0], lo[15:0]};
            end
            w = lo;
        end
    endtask
endmodule

/* File: verification/tb_tdcr_top.sv */
// Self-checking bench for the converter result path.
`timescale 1ns/1ps
module tb_tdcr_top
    import tdcr_pkg::*;
;
    logic                   clk;
    logic                   rst;
    logic [3:0]             addr;
    logic [DW-1:0]          wdata;
    logic [DW-1:0]          rdata;
    logic                   wr;
    logic                   rd;
    logic                   start_hit;
    logic [TW-1:0]          start_time;
    logic [NCH-1:0]         stop_hit;
    logic [NCH-1:0][TW-1:0] stop_time;
    logic [NCH-1:0]         stop_slope;
    logic                   alu_trigger;
    logic                   pll_locked;
    logic [1:0]             queue_empty_flag;
    logic [1:0]             queue_level_flag;
    logic                   irq;
    logic                   err;
    logic [DW-1:0]          exp_q[2][$];
    logic [DW-1:0]          got;
    logic [DW-1:0]          cfg;
    logic [TW-1:0]          start_ts;
    logic [TW-1:0]          offset;
    int                     start_idx;
    int                     num_errors;
    int                     cmp_count;
    int                     cyc;
    bit                     w16;

    tdcr_top tdcr_top_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .start_hit(start_hit), .start_time(start_time), .stop_hit(stop_hit),
        .stop_time(stop_time), .stop_slope(stop_slope), .alu_trigger(alu_trigger),
        .pll_locked(pll_locked), .queue_empty_flag(queue_empty_flag),
        .queue_level_flag(queue_level_flag), .irq(irq), .err(err));
    tdcr_host_model host_i (.clk(clk), .rdata(rdata), .queue_empty_flag(queue_empty_flag),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==================================================================
    // Checks and closing
    task automatic chk(input string name, input logic [DW-1:0] exp, input logic [DW-1:0] g);
        cmp_count++;
        if (g !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, g);
        end
    endtask
    task automatic conclude();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end
    // Level flags are judged only while the host is idle, as they may spike during reads.
    task automatic check_flags();
        chk("empty", 28'({exp_q[1].size() == 0, exp_q[0].size() == 0}), 28'(queue_empty_flag));
        chk("level", 28'({exp_q[1].size() >= 3, exp_q[0].size() >= 3}), 28'(queue_level_flag));
    endtask
    // ==================================================================
    // Stimulus with the reference model
    task automatic fire_start(input bit counted);
        logic [TW-1:0] t;
        t = TW'($urandom);
        @(posedge clk);
        start_hit  <= 1'b1;
        start_time <= t;
        @(posedge clk);
        start_hit  <= 1'b0;
        if (counted) begin
            start_idx++;
            start_ts = t;
        end
    endtask
    task automatic fire_stop(input int ch, input bit taken);
        logic [TW-1:0] t;
        logic          s;
        t = TW'($urandom);
        s = 1'($urandom);
        @(posedge clk);
        stop_hit[ch]   <= 1'b1;
        stop_time[ch]  <= t;
        stop_slope[ch] <= s;
        @(posedge clk);
        stop_hit       <= '0;
        if (taken) begin
            exp_q[ch / 4].push_back({2'(ch % 4), 8'(start_idx), s, TW'(t - start_ts + offset)});
        end
    endtask
    task automatic drain();
        for (int q = 0; q < 2; q++) begin
            while (exp_q[q].size() > 0) begin
                host_i.pop(q, w16, got);
                chk("word", exp_q[q].pop_front(), got);
            end
        end
    endtask
    // ==================================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        start_hit = 1'b0;
        start_time = '0;
        stop_hit = '0;
        stop_time = '0;
        stop_slope = '0;
        alu_trigger = 1'b0;
        pll_locked = 1'b1;
        start_idx = -1;
        w16 = 1'b0;
        void'($urandom(42936));
        repeat (8) @(posedge clk);
        check_flags();
        chk("irq_err", 28'h0000000, 28'({irq, err}));
        chk("rdata", 28'h0000000, rdata);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        offset = TW'($urandom % 65536);
        cfg = 28'h0200000 | 28'(offset);
        host_i.reg_wr(ADR_FILL, 28'h0000003);
        host_i.reg_wr(ADR_CFG, cfg);
        fire_stop(0, 1'b0);
        fire_start(1'b1);
        repeat (2) @(posedge clk);
        for (int k = 0; k < 8; k++) begin
            if (k == 5) begin
                fire_start(1'b1);
                repeat (2) @(posedge clk);
            end
            fire_stop(int'($urandom % 8), 1'b1);
        end
        repeat (10) @(posedge clk);
        check_flags();
        drain();
        check_flags();
        host_i.reg_wr(ADR_BUSW, BUS16_CODE);
        w16 = 1'b1;
        fire_stop(5, 1'b1);
        fire_stop(2, 1'b1);
        drain();
        w16 = 1'b0;
        host_i.reg_wr(ADR_BUSW, 28'h0000000);
        fire_stop(3, 1'b1);
        repeat (6) @(posedge clk);
        host_i.reg_wr(ADR_CTRL, 28'h1000000);
        start_idx = -1;
        repeat (12) @(posedge clk);
        check_flags();
        drain();
        host_i.reg_wr(ADR_CFG, cfg | 28'h0800000);
        fire_start(1'b1);
        fire_stop(6, 1'b1);
        repeat (6) @(posedge clk);
        alu_trigger <= 1'b1;
        @(posedge clk);
        alu_trigger <= 1'b0;
        exp_q[1].delete();
        start_idx = -1;
        repeat (6) @(posedge clk);
        check_flags();
        host_i.reg_wr(ADR_CFG, cfg | 28'h0400000);
        repeat (6) @(posedge clk);
        fire_start(1'b1);
        fire_start(1'b0);
        repeat (2) @(posedge clk);
        fire_stop(1, 1'b1);
        fire_stop(7, 1'b1);
        drain();
        host_i.reg_rd(4'hF, got);
        chk("unmapped", 28'h0000000, got);
        host_i.reg_wr(ADR_ERRM, 28'h4000000);
        host_i.reg_wr(ADR_STAT, 28'h0800000);
        repeat (4) @(posedge clk);
        chk("irq_err", 28'h0000000, 28'({irq, err}));
        pll_locked <= 1'b0;
        repeat (4) @(posedge clk);
        chk("irq_err", 28'h0000003, 28'({irq, err}));
        pll_locked <= 1'b1;
        host_i.reg_wr(ADR_TIMER, 28'h0000005);
        host_i.reg_wr(ADR_STAT, 28'h2000000);
        host_i.reg_wr(ADR_CTRL, 28'h4000000);
        fire_stop(4, 1'b1);
        repeat (6) @(posedge clk);
        chk("timer_irq", 28'h0000000, 28'(irq));
        @(posedge clk);
        chk("timer_irq", 28'h0000001, 28'(irq));
        host_i.reg_wr(ADR_CTRL, 28'h0000000);
        // Stalled output queue backs up into the hit queue, which then drops.
        for (int k = 0; k < 300; k++) begin
            fire_stop(0, k < 288);
        end
        check_flags();
        drain();
        host_i.reg_rd(ADR_STAT, got);
        chk("status", 28'h2001901, got);
        host_i.reg_rd(ADR_STAT, got);
        chk("status", 28'h2001800, got);
        conclude();
    end
endmodule
